// [hdl/lsc_serial_ctrl.sv]
// serial LED sink control: 25-bit shift register on the link clock, on/off and
// group latches, forced blanking, group brightness and an AXI4-Lite register slave
// assumes shift_clock comes from the host and may stop between frames; the host
// holds the shifted word still while the strobe is high
`timescale 1ns/1ps
`include "lsc_map.svh"

// Overview of operation
// RULE1: one common 25-bit shift register from serial input
// RULE2: shift clock rise captures input into LSB
// RULE3: shift clock rise moves bits toward MSB
// RULE4: serial output shows shift register MSB
// RULE5: strobe rise copies word; latches otherwise hold
// RULE6: force-off high turns all 24 sinks off
// RULE7: force-off low: sink follows its on/off bit; here sw_force, set by a bus write, still blanks it
// RULE8: one brightness per colour group of eight
// RULE9: brightness picks one of 128 linear levels
// RULE10: current equals full scale times code/127
// RULE11: new brightness applies at once
// RULE12: host writes brightness before enabling outputs
// RULE13: host loads on/off before releasing force-off
// RULE14: host clears on/off bits of absent LEDs
// RULE15: word bit 24 picks on/off or control latch
// RULE16: control bits hold red, green, blue levels
// RULE17: control bits 23-21 select detect mode
// RULE18: shift on link clock, latch on strobe edge
module lsc_serial_ctrl #(
	parameter int FULL_SCALE_UA = 35000,
	parameter int CUR_W         = 16
) (
	// system clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic                     clock_enable,
	// axi4-lite write
	input  wire logic [`LSC_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [`LSC_DATA_W-1:0]   s_axi_wdata,
	input  wire logic [`LSC_STRB_W-1:0]   s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic      [1:0]               s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// axi4-lite read
	input  wire logic [`LSC_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic      [`LSC_DATA_W-1:0]   s_axi_rdata,
	output logic      [1:0]               s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// serial link
	input  wire logic                     shift_clock,
	input  wire logic                     serial_data_input,
	output logic                          serial_data_output,
	input  wire logic                     transfer_strobe,
	input  wire logic                     force_off,
	// sink drive
	output logic      [`LSC_GROUP_N-1:0]  red_sink_outputs,
	output logic      [`LSC_GROUP_N-1:0]  green_sink_outputs,
	output logic      [`LSC_GROUP_N-1:0]  blue_sink_outputs,
	// group brightness and detect mode
	output logic      [`LSC_LEVEL_W-1:0]  red_group_brightness,
	output logic      [`LSC_LEVEL_W-1:0]  green_group_brightness,
	output logic      [`LSC_LEVEL_W-1:0]  blue_group_brightness,
	output logic      [CUR_W-1:0]         red_sink_current_ua,
	output logic      [CUR_W-1:0]         green_sink_current_ua,
	output logic      [CUR_W-1:0]         blue_sink_current_ua,
	output logic      [`LSC_MODE_W-1:0]   detect_mode
);

	// ======================================================================
	// parameter check
	if (CUR_W < 8 || CUR_W > 24) begin : g_bad_width
		$error("current width out of the supported range");
	end

	// idle bus ports ready at reset so the first request needs no wait
	localparam lsc_pkg::lsc_core_t CORE_RST = '{
		awready  : 1'b1,
		wready   : 1'b1,
		arready  : 1'b1,
		sw_force : `LSC_RST_SW_FORCE,
		default  : '0
	};

	lsc_pkg::lsc_link_t ls;
	lsc_pkg::lsc_link_t next_ls;
	lsc_pkg::lsc_core_t st;
	lsc_pkg::lsc_core_t next_st;
	logic               strobe_rise;
	logic               forced;
	lsc_pkg::lsc_reg_t  wr_sel;
	lsc_pkg::lsc_reg_t  rd_sel;

	// ======================================================================
	// address decode, shared by the read and write paths
	function automatic lsc_pkg::lsc_reg_t reg_decode(input logic [`LSC_ADDR_W-1:0] addr);
		unique case ({addr[`LSC_ADDR_W-1:2], 2'b00})
			`LSC_OFF_CTRL:   reg_decode = lsc_pkg::LSC_REG_CTRL;
			`LSC_OFF_ONOFF:  reg_decode = lsc_pkg::LSC_REG_ONOFF;
			`LSC_OFF_GROUP:  reg_decode = lsc_pkg::LSC_REG_GROUP;
			`LSC_OFF_STATUS: reg_decode = lsc_pkg::LSC_REG_STATUS;
			default:         reg_decode = lsc_pkg::LSC_REG_NONE;
		endcase
	endfunction : reg_decode

	// ======================================================================
	// link side: shift register on the host's clock
	// shift one place and take the new bit; output copy kept in step with bit 24
	always_comb begin
		next_ls       = ls;
		next_ls.shreg = {ls.shreg[`LSC_WORD_W-2:0], serial_data_input}; // [RULE1] [RULE2] [RULE3] [RULE18]
		next_ls.sdo   = next_ls.shreg[`LSC_WORD_W-1];                    // [RULE4]
	end

	// the enable lives in the system domain, so it does not gate this side
	always_ff @(posedge shift_clock or negedge rst_n) begin
		if (!rst_n) begin
			ls <= '0;
		end else begin
			ls <= next_ls;
		end
	end

	// ======================================================================
	// system side: synchronisers, latches, sink gating and bus slave
	// the shifted word crosses only under the synchronised strobe edge; the host
	// gives no shift edge while the strobe is high, so the word is quiet then
	always_comb begin
		next_st           = st;
		// two-flop synchronisers for the strobe and force pins
		next_st.strobe_s1 = transfer_strobe;
		next_st.strobe_s2 = st.strobe_s1;
		next_st.strobe_d  = st.strobe_s2;
		next_st.force_s1  = force_off;
		next_st.force_s2  = st.force_s1;
		strobe_rise       = st.strobe_s2 & ~st.strobe_d;
		forced            = st.force_s2 | st.sw_force;

		// strobe edge steers the low 24 bits by the select bit
		if (strobe_rise) begin                                           // [RULE5] [RULE18]
			if (ls.shreg[`LSC_SEL_BIT]) begin                            // [RULE15]
				next_st.group      = ls.shreg[`LSC_LATCH_W-1:0];
				next_st.group_seen = 1'b1;
			end else begin
				next_st.onoff      = ls.shreg[`LSC_LATCH_W-1:0];
				next_st.onoff_seen = 1'b1;
			end
		end

		// group fields follow the control latch in the same edge
		next_st.red  = next_st.group[`LSC_RED_MSB:`LSC_RED_LSB];        // [RULE8] [RULE16] [RULE11]
		next_st.grn  = next_st.group[`LSC_GRN_MSB:`LSC_GRN_LSB];        // [RULE16]
		next_st.blu  = next_st.group[`LSC_BLU_MSB:`LSC_BLU_LSB];        // [RULE16]
		next_st.mode = next_st.group[`LSC_MODE_MSB:`LSC_MODE_LSB];      // [RULE17]

		// blanking overrides every on/off bit
		next_st.sinks = forced ? '0 : next_st.onoff;                     // [RULE6] [RULE7]

		// write channel: address and data taken in either order
		wr_sel = reg_decode(st.aw_addr);
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
			wr_sel          = reg_decode(s_axi_awaddr);
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (next_st.aw_held && next_st.w_held) begin
			if (wr_sel == lsc_pkg::LSC_REG_CTRL && next_st.w_strb[0]) begin
				next_st.sw_force = next_st.w_data[`LSC_CTRL_FORCE_BIT];
			end
			next_st.bresp   = (wr_sel == lsc_pkg::LSC_REG_NONE) ? `LSC_RESP_SLVERR : `LSC_RESP_OKAY;
			next_st.bvalid  = 1'b1;
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
		end
		// no new write until the response is gone
		next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
		next_st.wready  = ~next_st.w_held & ~next_st.bvalid;

		// read channel: one beat answered on the edge after the address
		rd_sel = reg_decode(s_axi_araddr);
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = `LSC_RESP_OKAY;
			next_st.rdata  = '0;
			unique case (rd_sel)
				lsc_pkg::LSC_REG_CTRL: begin
					next_st.rdata[`LSC_CTRL_FORCE_BIT] = st.sw_force;
				end
				lsc_pkg::LSC_REG_ONOFF: begin
					next_st.rdata[`LSC_LATCH_W-1:0] = st.onoff;
				end
				lsc_pkg::LSC_REG_GROUP: begin
					next_st.rdata[`LSC_LATCH_W-1:0] = st.group;
				end
				lsc_pkg::LSC_REG_STATUS: begin
					next_st.rdata[`LSC_STAT_FORCED_BIT] = forced;
					next_st.rdata[`LSC_STAT_ONOFF_BIT]  = st.onoff_seen;
					next_st.rdata[`LSC_STAT_GROUP_BIT]  = st.group_seen;
				end
				lsc_pkg::LSC_REG_NONE: begin
					next_st.rresp = `LSC_RESP_SLVERR;
				end
			endcase
		end
		next_st.arready = ~next_st.rvalid;
	end

	// a low enable freezes the whole system side, synchronisers included
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= CORE_RST;
		end else if (clock_enable) begin
			st <= next_st;
		end
	end

	// ======================================================================
	// brightness to current, one scaler per colour group
	logic [2:0][`LSC_LEVEL_W-1:0] grp_level;
	logic [2:0][CUR_W-1:0]        grp_current;

	assign grp_level = {st.blu, st.grn, st.red};

	for (genvar g = 0; g < 3; g++) begin : g_scale
		lsc_current_scale #(
			.FULL_SCALE_UA (FULL_SCALE_UA),
			.CUR_W         (CUR_W)
		) u_scale (
			.clock        (clock),
			.rst_n        (rst_n),
			.clock_enable (clock_enable),
			.level        (grp_level[g]),
			.current_ua   (grp_current[g])
		);
	end

	// ======================================================================
	// outputs, all straight from registers
	assign serial_data_output     = ls.sdo;
	assign s_axi_awready          = st.awready;
	assign s_axi_wready           = st.wready;
	assign s_axi_bvalid           = st.bvalid;
	assign s_axi_bresp            = st.bresp;
	assign s_axi_arready          = st.arready;
	assign s_axi_rvalid           = st.rvalid;
	assign s_axi_rdata            = st.rdata;
	assign s_axi_rresp            = st.rresp;
	assign red_sink_outputs       = st.sinks[`LSC_ONOFF_RED_LSB +: `LSC_GROUP_N];
	assign green_sink_outputs     = st.sinks[`LSC_ONOFF_GRN_LSB +: `LSC_GROUP_N];
	assign blue_sink_outputs      = st.sinks[`LSC_ONOFF_BLU_LSB +: `LSC_GROUP_N];
	assign red_group_brightness   = st.red;
	assign green_group_brightness = st.grn;
	assign blue_group_brightness  = st.blu;
	assign red_sink_current_ua    = grp_current[0];
	assign green_sink_current_ua  = grp_current[1];
	assign blue_sink_current_ua   = grp_current[2];
	assign detect_mode            = st.mode;

	// ======================================================================
	// assertions, link side
	a_shift_capture: assert property (@(posedge shift_clock) disable iff (!rst_n) // [RULE2]
		1'b1 |=> ls.shreg[0] == $past(serial_data_input))
		else $error("serial input bit not captured at the low end");
	a_shift_move: assert property (@(posedge shift_clock) disable iff (!rst_n) // [RULE3]
		1'b1 |=> ls.shreg[`LSC_WORD_W-1:1] == $past(ls.shreg[`LSC_WORD_W-2:0]))
		else $error("shift register did not move one place up");
	a_serial_data_output_msb: assert property (@(posedge shift_clock) disable iff (!rst_n) // [RULE4]
		1'b1 |=> serial_data_output == $past(ls.shreg[`LSC_WORD_W-2]))
		else $error("serial output does not show the top bit");

	// ======================================================================
	// assertions, system side
	a_onoff_load: assert property (@(posedge clock) disable iff (!rst_n) // [RULE15]
		clock_enable && strobe_rise && !ls.shreg[`LSC_SEL_BIT]
		|=> st.onoff == $past(ls.shreg[`LSC_LATCH_W-1:0]) && $stable(st.group))
		else $error("on/off latch not loaded from a select-low word");
	a_group_load: assert property (@(posedge clock) disable iff (!rst_n) // [RULE15]
		clock_enable && strobe_rise && ls.shreg[`LSC_SEL_BIT]
		|=> st.group == $past(ls.shreg[`LSC_LATCH_W-1:0]) && $stable(st.onoff))
		else $error("control latch not loaded from a select-high word");
	a_latch_hold: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
		!strobe_rise |=> $stable(st.onoff) && $stable(st.group))
		else $error("latch changed without a strobe edge");
	a_force_off: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
		clock_enable && forced |=> red_sink_outputs == '0 && green_sink_outputs == '0
		&& blue_sink_outputs == '0)
		else $error("a sink stayed on while forced off");
	a_out_follow: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
		clock_enable && !forced |=> st.sinks == st.onoff)
		else $error("sinks do not follow the on/off latch");
	a_bright_apply: assert property (@(posedge clock) disable iff (!rst_n) // [RULE11]
		clock_enable && strobe_rise && ls.shreg[`LSC_SEL_BIT]
		|=> red_group_brightness == $past(ls.shreg[`LSC_RED_MSB:`LSC_RED_LSB])
		&& blue_group_brightness == $past(ls.shreg[`LSC_BLU_MSB:`LSC_BLU_LSB]))
		else $error("brightness not applied on the latch edge");
	a_mode_field: assert property (@(posedge clock) disable iff (!rst_n) // [RULE17]
		1'b1 |-> detect_mode == st.group[`LSC_MODE_MSB:`LSC_MODE_LSB]
		&& green_group_brightness == st.group[`LSC_GRN_MSB:`LSC_GRN_LSB])
		else $error("detect mode or green level out of its field");
	a_wr_resp: assert property (@(posedge clock) disable iff (!rst_n)
		clock_enable && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid && !s_axi_awready)
		else $error("write response missing after both halves");
	a_rd_resp: assert property (@(posedge clock) disable iff (!rst_n)
		clock_enable && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data missing after the address");
	// a pending answer must refuse the next request on its path, or a second
	// write could overwrite the held response before the master saw it
	a_wr_refuse: assert property (@(posedge clock) disable iff (!rst_n)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write path ready while a response is pending");
	a_rd_refuse: assert property (@(posedge clock) disable iff (!rst_n)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read address ready while read data is pending");

	// ======================================================================
	// covers of the main scenarios
	c_onoff_load: cover property (@(posedge clock) disable iff (!rst_n)
		strobe_rise && !ls.shreg[`LSC_SEL_BIT]);
	c_group_load: cover property (@(posedge clock) disable iff (!rst_n)
		strobe_rise && ls.shreg[`LSC_SEL_BIT]);
	c_forced_lit: cover property (@(posedge clock) disable iff (!rst_n)
		forced && st.onoff != '0);
	c_bus_write: cover property (@(posedge clock) disable iff (!rst_n)
		s_axi_bvalid && s_axi_bready && s_axi_bresp == `LSC_RESP_OKAY);

endmodule : lsc_serial_ctrl

// [hdl/lsc_map.svh]
// constants of the serial LED sink control block: word layout, register map, bus codes
// assumes inclusion by bare name from the package and the design files
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

// ==========================================================================
// serial word and latch layout
`define LSC_WORD_W          25
`define LSC_LATCH_W         24
`define LSC_SEL_BIT         24
`define LSC_GROUP_N         8
`define LSC_LEVEL_W         7
`define LSC_LEVEL_MAX       7'h7F
`define LSC_RED_LSB         0
`define LSC_RED_MSB         6
`define LSC_GRN_LSB         7
`define LSC_GRN_MSB         13
`define LSC_BLU_LSB         14
`define LSC_BLU_MSB         20
`define LSC_MODE_LSB        21
`define LSC_MODE_MSB        23
`define LSC_MODE_W          3
`define LSC_MODE_SHORT_BIT  2
`define LSC_ONOFF_RED_LSB   0
`define LSC_ONOFF_GRN_LSB   8
`define LSC_ONOFF_BLU_LSB   16

// ==========================================================================
// register bus map, byte addresses
`define LSC_ADDR_W          5
`define LSC_DATA_W          32
`define LSC_STRB_W          4
`define LSC_OFF_CTRL        5'h00
`define LSC_OFF_ONOFF       5'h04
`define LSC_OFF_GROUP       5'h08
`define LSC_OFF_STATUS      5'h0C
`define LSC_CTRL_FORCE_BIT  0
`define LSC_STAT_FORCED_BIT 0
`define LSC_STAT_ONOFF_BIT  1
`define LSC_STAT_GROUP_BIT  2
`define LSC_RESP_OKAY       2'h0
`define LSC_RESP_SLVERR     2'h2
`define LSC_RST_SW_FORCE    1'h0

`endif

// [hdl/lsc_pkg.sv]
// types shared by the serial LED sink control block
// assumes lsc_map.svh is on the include path
`include "lsc_map.svh"

package lsc_pkg;

	// ======================================================================
	// register select decoded from a bus address
	typedef enum logic [2:0] {
		LSC_REG_CTRL   = 3'h0,
		LSC_REG_ONOFF  = 3'h1,
		LSC_REG_GROUP  = 3'h3,
		LSC_REG_STATUS = 3'h2,
		LSC_REG_NONE   = 3'h6
	} lsc_reg_t;

	// ======================================================================
	// state on the link (shift clock) side
	typedef struct packed {
		logic [`LSC_WORD_W-1:0] shreg;
		logic                   sdo;
	} lsc_link_t;

	// ======================================================================
	// state on the system clock side
	typedef struct packed {
		logic                    strobe_s1;
		logic                    strobe_s2;
		logic                    strobe_d;
		logic                    force_s1;
		logic                    force_s2;
		logic [`LSC_LATCH_W-1:0] onoff;
		logic [`LSC_LATCH_W-1:0] group;
		logic                    onoff_seen;
		logic                    group_seen;
		logic [`LSC_LATCH_W-1:0] sinks;
		logic [`LSC_LEVEL_W-1:0] red;
		logic [`LSC_LEVEL_W-1:0] grn;
		logic [`LSC_LEVEL_W-1:0] blu;
		logic [`LSC_MODE_W-1:0]  mode;
		logic                    sw_force;
		logic                    awready;
		logic                    aw_held;
		logic [`LSC_ADDR_W-1:0]  aw_addr;
		logic                    wready;
		logic                    w_held;
		logic [`LSC_DATA_W-1:0]  w_data;
		logic [`LSC_STRB_W-1:0]  w_strb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [`LSC_DATA_W-1:0]  rdata;
		logic [1:0]              rresp;
	} lsc_core_t;

endpackage : lsc_pkg

// [hdl/lsc_current_scale.sv]
// scales one group brightness level to a sink current figure in microamps
// assumes level comes from logic on the same clock
`timescale 1ns/1ps
`include "lsc_map.svh"

module lsc_current_scale #(
	parameter int FULL_SCALE_UA = 35000,
	parameter int CUR_W         = 16
) (
	// clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    clock_enable,
	// level in, current out
	input  wire logic [`LSC_LEVEL_W-1:0] level,
	output logic      [CUR_W-1:0]        current_ua
);

	localparam int PW = CUR_W + `LSC_LEVEL_W;
	localparam logic [PW-1:0] FS_P  = PW'(FULL_SCALE_UA);
	localparam logic [PW-1:0] MAX_P = PW'(`LSC_LEVEL_MAX);

	// ======================================================================
	// parameter check
	if (FULL_SCALE_UA <= 0 || FULL_SCALE_UA >= (2 ** CUR_W)) begin : g_bad
		$error("full scale current does not fit the output width");
	end

	typedef struct packed {
		logic [CUR_W-1:0] cur;
	} lsc_scale_t;

	lsc_scale_t st;
	lsc_scale_t next_st;
	logic [PW-1:0] prod;
	logic [PW-1:0] quot;

	// linear 128-step law, zero at code 0, full scale at the top code
	always_comb begin
		prod        = FS_P * {{CUR_W{1'b0}}, level};   // [RULE9]
		quot        = prod / MAX_P;                    // [RULE10]
		next_st.cur = quot[CUR_W-1:0];
	end

	// one register stage; a new level shows on the next edge   [RULE11]
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else if (clock_enable) begin
			st <= next_st;
		end
	end

	assign current_ua = st.cur;

	// ======================================================================
	// assertions
	a_scale_full: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
		clock_enable && level == `LSC_LEVEL_MAX |=> current_ua == CUR_W'(FULL_SCALE_UA))
		else $error("top level code does not give full scale");
	a_scale_zero: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
		clock_enable && level == '0 |=> current_ua == '0)
		else $error("level zero does not give zero current");
	c_scale_full: cover property (@(posedge clock) disable iff (!rst_n)
		current_ua == CUR_W'(FULL_SCALE_UA));

endmodule : lsc_current_scale

// [tb/lsc_host_model.sv]
// behavioural serial host for the LED sink control block
// assumes the bench calls send() and that the link clock stands still between frames
`timescale 1ns/1ps

// ==========================================================================
// host model
module lsc_host_model (
	// link pins toward the block
	output logic        shift_clock,
	output logic        serial_data_input,
	output logic        transfer_strobe,
	input  wire logic   serial_data_output,
	// bits seen returning on the cascade output
	output logic [24:0] echo
);
	// idle link: clock low, strobe low
	initial begin
		{shift_clock, serial_data_input, transfer_strobe, echo} = '0;
	end

	// one frame: 25 bits msb first at 160 ns, then a long strobe
	// bench orders frames: control before release of blanking
	// unused outputs get on/off bits of 0 from the bench
	task automatic send(input logic [24:0] word);
		int i;
		#13;
		for (i = 24; i >= 0; i--) begin
			serial_data_input = word[i];
			#80 shift_clock = 1'b1;
			#1 echo = {echo[23:0], serial_data_output};
			#79 shift_clock = 1'b0;
		end
		serial_data_input = ~word[0]; // no stale value once released
		#80 transfer_strobe = 1'b1;
		#200 transfer_strobe = 1'b0; // well over three system clocks high
		#80;
	endtask : send
endmodule : lsc_host_model

// [tb/tb_lsc_serial_ctrl.sv]
// self-checking bench for the serial LED sink control block
// assumes the host model drives the link and the bench drives the register bus
`timescale 1ns/1ps
`include "lsc_map.svh"

module tb_lsc_serial_ctrl;
	localparam int FS = 35000;
	logic        clock, rst_n, force_off, serial_data_output, clock_enable;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        shift_clock, serial_data_input, transfer_strobe;
	logic [7:0]  red_sink_outputs, green_sink_outputs, blue_sink_outputs;
	logic [6:0]  red_group_brightness, green_group_brightness, blue_group_brightness;
	logic [15:0] red_sink_current_ua, green_sink_current_ua, blue_sink_current_ua;
	logic [2:0]  detect_mode;
	logic [24:0] echo, w;
	int          n_errors, comparisons, m;

	// ======================================================================
	// design, host and clock
	lsc_serial_ctrl #(.FULL_SCALE_UA(FS), .CUR_W(16)) uut (.*);
	lsc_host_model host (.*);
	initial clock = 1'b0;
	always #20 clock = ~clock;

	// ======================================================================
	// checking and closing
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out

	// bus write: address and data offered together, response waited for
	task automatic axw(input logic [4:0] a, input logic [31:0] d);
		int n;
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) begin
			n_errors++;
			close_out();
		end
		@(posedge clock);
	endtask : axw

	// bus read: rdata and rresp taken at the handshake edge
	task automatic axr(input logic [4:0] a);
		int n;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		{rd, rs} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		if (n == 50) begin
			n_errors++;
			close_out();
		end
		@(posedge clock);
	endtask : axr

	// ======================================================================
	// main sequence; outputs stay blanked until both latches are loaded
	initial begin
		{rst_n, force_off, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, n_errors, comparisons} = '0;
		s_axi_wstrb = 4'hF;
		clock_enable = 1'b1;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		w = {1'b1, 3'h5, 7'h2A, 7'h00, 7'h7F};
		host.send(w);
		host.send({1'b0, 24'hA53C81});
		repeat (6) @(posedge clock);
		chk("cascade", 32'(echo), 32'({w[23:0], 1'b0}));
		chk("serial out", 32'(serial_data_output), 0);
		chk("forced", 32'({blue_sink_outputs, green_sink_outputs, red_sink_outputs}), 0);
		force_off <= 1'b0;
		repeat (6) @(posedge clock);
		chk("sinks", 32'({blue_sink_outputs, green_sink_outputs, red_sink_outputs}), 32'hA53C81);
		chk("blue level", 32'(blue_group_brightness), 32'h2A);
		chk("blue current", 32'(blue_sink_current_ua), FS * 42 / 127);
		$display("test link done");
		// every detect mode, with new levels applied at once
		for (m = 0; m < 8; m++) begin
			host.send({1'b1, 3'(m), 7'(m), 7'(127 - m), 7'(m * 18)});
			repeat (6) @(posedge clock);
			chk("mode", 32'(detect_mode), m);
			chk("red level", 32'(red_group_brightness), m * 18);
			chk("green level", 32'(green_group_brightness), 127 - m);
			chk("red current", 32'(red_sink_current_ua), FS * (m * 18) / 127);
			chk("green current", 32'(green_sink_current_ua), FS * (127 - m) / 127);
			chk("red sinks", 32'(red_sink_outputs), 32'h81);
		end
		$display("test modes done");
		axr(`LSC_OFF_ONOFF);
		chk("onoff reg", rd, 32'h00A53C81);
		axr(`LSC_OFF_GROUP);
		chk("group reg", rd, {8'h00, 3'h7, 7'h07, 7'h78, 7'h7E});
		axr(5'h10);
		chk("unmapped", 32'(rs), 32'(`LSC_RESP_SLVERR));
		axw(5'h14, 32'h0);
		chk("unmapped wr", 32'(rs), 32'(`LSC_RESP_SLVERR));
		axw(`LSC_OFF_CTRL, 32'h1);
		chk("write resp", 32'(rs), 32'(`LSC_RESP_OKAY));
		repeat (4) @(posedge clock);
		chk("sw force", 32'(blue_sink_outputs), 0);
		axr(`LSC_OFF_CTRL);
		chk("ctrl reg", rd, 32'h1);
		axw(`LSC_OFF_CTRL, 32'h0);
		repeat (4) @(posedge clock);
		chk("unforced", 32'(blue_sink_outputs), 32'hA5);
		force_off <= 1'b1;
		repeat (5) @(posedge clock);
		chk("pin force", 32'(green_sink_outputs), 0);
		axr(`LSC_OFF_STATUS);
		chk("status", rd, 32'h7);
		// a frozen system side misses the strobe, so the levels must hold
		clock_enable <= 1'b0;
		host.send({1'b1, 24'h0});
		@(posedge clock);
		clock_enable <= 1'b1;
		repeat (6) @(posedge clock);
		chk("frozen level", 32'(red_group_brightness), 32'h7E);
		chk("serial top", 32'(serial_data_output), 1);
		$display("test bus done");
		close_out();
	end
endmodule : tb_lsc_serial_ctrl
